// ==== igd_dispatch.sv ====
// Issue group dispatch and pipeline stall control.
`timescale 1ns/1ps
`include "igd_defines.svh"
module igd_dispatch (
	// Clock and reset
	input  wire logic                     clk,
	input  wire logic                     rstn,
	// Program memory
	output logic                          progAddrValid,
	output logic [`IGD_ADDR_W-1:0]        progAddr,
	input  wire logic                     progReady,
	input  wire igd_pkg::fetch_group_t    progGroup,
	// Data memory accesses in execute stage three
	input  wire logic                     dataValid0,
	input  wire logic [`IGD_ADDR_W-1:0]   dataAddr0,
	input  wire logic                     dataValid1,
	input  wire logic [`IGD_ADDR_W-1:0]   dataAddr1,
	input  wire logic                     dataReady,
	// Branch and no-operation from decode
	input  wire logic                     branchIssue,
	input  wire logic [`IGD_ADDR_W-1:0]   branchTarget,
	input  wire logic                     nopIssue,
	input  wire logic [`IGD_NOP_CNT_W-1:0] nopCount,
	// Issue group to decode
	output logic                          issueValid,
	output igd_pkg::fetch_group_t         issueGroup,
	output igd_pkg::slot_mask_t           issueMask,
	// Status
	output logic                          pipeStall,
	output logic [`IGD_NSTAGE-1:0]        stageValid,
	output logic                          loadWriteback
);
	import igd_pkg::*;

	// ***********************************************
	// Stage registers
	// ***********************************************
	logic [`IGD_NSTAGE-1:0]   stageValid_r;
	logic [`IGD_NSTAGE-1:0]   stageValid_nxt;
	logic [`IGD_ADDR_W-1:0]   pc_r;
	fetch_group_t             prGroup_r;
	fetch_group_t             dpGroup_r;
	slot_mask_t               doneMask_r;
	igd_state_t               state_r;
	igd_state_t               state_nxt;
	logic [2:0]               brCnt_r;
	logic                     brPend_r;
	logic [`IGD_ADDR_W-1:0]   brTarget_r;
	logic                     brRedir_r;
	logic [`IGD_ADDR_W-1:0]   psAddr_r;
	fetch_group_t             issueGroup_r;
	slot_mask_t               issueMask_r;
	logic                     issueValid_r;
	logic                     nopBusy;
	igd_stall_if              stallBus ();

	// ***********************************************
	// Stall causes
	// ***********************************************
	igd_mem_stall uMem (
		.clk           (clk),
		.rstn          (rstn),
		.progWaitValid (stageValid_r[2]),
		.progReady     (progReady),
		.dataValid0    (dataValid0 && stageValid_r[`IGD_ST_E3]),
		.dataAddr0     (dataAddr0),
		.dataValid1    (dataValid1 && stageValid_r[`IGD_ST_E3]),
		.dataAddr1     (dataAddr1),
		.dataReady     (dataReady),
		.stall         (stallBus.src)
	);

	wire memStall = stallBus.dst.bankHit || stallBus.dst.memWait;
	wire brDone   = brPend_r && (brCnt_r == 3'(`IGD_BRANCH_SLOTS)) && !memStall;

	igd_nop_timer uNop (
		.clk        (clk),
		.rstn       (rstn),
		.advance    (!memStall),
		.load       (nopIssue && issueValid_r),
		.count      (nopCount),
		.branchDone (brDone),
		.busy       (nopBusy)
	);

	// ***********************************************
	// Issue group split
	// ***********************************************
	slot_mask_t pbits;
	slot_mask_t pending;
	slot_mask_t grpMask;
	logic       grpEnd;
	genvar      g;
	generate
		for (g = 0; g < `IGD_SLOTS; g++) begin : gPbit
			assign pbits[g] = dpGroup_r[g][`IGD_PBIT_POS];
		end
	endgenerate
	assign pending = ~doneMask_r;

	// Collect slots from the first pending one until a clear marker bit.
	always_comb begin
		logic inGrp;
		logic stop;
		inGrp   = 1'b0;
		stop    = 1'b0;
		grpMask = '0;
		for (int i = 0; i < `IGD_SLOTS; i++) begin
			if (pending[i] && !stop) begin
				inGrp      = 1'b1;
				grpMask[i] = 1'b1;
				if (!pbits[i]) begin
					stop = 1'b1;
				end
			end
		end
		grpEnd = ((doneMask_r | grpMask) == {`IGD_SLOTS{1'b1}}) || !inGrp;
	end

	wire dpValid    = stageValid_r[`IGD_ST_DP];
	wire splitStall = dpValid && !grpEnd;
	// A counted no-operation holds issue already in the cycle that loads it; a finished branch overrides it.
	wire nopLoad    = nopIssue && issueValid_r && (nopCount > 4'h1);
	wire holdAll    = memStall || ((nopBusy || nopLoad) && !brDone);
	wire dpAdvance  = dpValid && !holdAll;
	wire frontHold  = holdAll || splitStall;
	wire frontGo    = !memStall && !frontHold;
	wire brTake     = branchIssue && issueValid_r && !brPend_r;

	// The target enters address generate behind the groups already fetched, which fill the delay slots.
	wire [`IGD_ADDR_W-1:0] pcNext = brTake ? branchTarget : (brRedir_r ? brTarget_r : pc_r + 32'h20);

	always_comb begin
		state_nxt = state_r;
		case (state_r)
			IGD_RUN:    state_nxt = splitStall ? IGD_SPLIT : (nopBusy ? IGD_NOPRUN : IGD_RUN);
			IGD_SPLIT:  state_nxt = (dpAdvance && grpEnd) ? IGD_RUN : IGD_SPLIT;
			IGD_NOPRUN: state_nxt = nopBusy ? IGD_NOPRUN : IGD_RUN;
			default:    state_nxt = IGD_RUN;
		endcase
	end

	// ***********************************************
	// Pipeline advance
	// ***********************************************
	always_comb begin
		stageValid_nxt = stageValid_r;
		if (!memStall) begin
			stageValid_nxt[`IGD_NSTAGE-1:`IGD_ST_DP+1] =
				{stageValid_r[`IGD_NSTAGE-2:`IGD_ST_DP+1], dpAdvance};
			if (!frontHold) begin
				stageValid_nxt[`IGD_ST_DP:0] = {stageValid_r[`IGD_ST_DP-1:0], 1'b1};
			end else if (dpAdvance && grpEnd) begin
				stageValid_nxt[`IGD_ST_DP] = 1'b0;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			stageValid_r <= '0;
			state_r      <= IGD_RUN;
		end else begin
			stageValid_r <= stageValid_nxt;
			state_r      <= state_nxt;
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			pc_r      <= '0;
			psAddr_r  <= '0;
			prGroup_r <= '0;
			dpGroup_r <= '0;
		end else if (frontGo) begin
			pc_r      <= pcNext;
			psAddr_r  <= pc_r;
			prGroup_r <= progGroup;
			dpGroup_r <= prGroup_r;
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			doneMask_r <= '0;
		end else if (dpAdvance) begin
			doneMask_r <= grpEnd ? '0 : (doneMask_r | grpMask);
		end
	end

	// ***********************************************
	// Branch delay slot tracking
	// ***********************************************
	always_ff @(posedge clk) begin
		if (!rstn) begin
			brPend_r   <= 1'b0;
			brRedir_r  <= 1'b0;
			brCnt_r    <= '0;
			brTarget_r <= '0;
		end else if (brTake) begin
			brPend_r   <= 1'b1;
			brRedir_r  <= !frontGo;
			brCnt_r    <= 3'h1;
			brTarget_r <= branchTarget;
		end else begin
			if (frontGo) begin
				brRedir_r <= 1'b0;
			end
			if (brDone) begin
				brPend_r <= 1'b0;
			end else if (brPend_r && !memStall) begin
				brCnt_r <= brCnt_r + 3'h1;
			end
		end
	end

	// ***********************************************
	// Issue output
	// ***********************************************
	always_ff @(posedge clk) begin
		if (!rstn) begin
			issueValid_r <= 1'b0;
			issueGroup_r <= '0;
			issueMask_r  <= '0;
		end else if (!memStall) begin
			issueValid_r <= dpAdvance;
			issueGroup_r <= dpGroup_r;
			issueMask_r  <= grpMask;
		end
	end

	// The held issue group is announced once, in the cycle in which it moves on.
	assign issueValid    = issueValid_r && !memStall;
	assign issueGroup    = issueGroup_r;
	assign issueMask     = issueMask_r;
	assign progAddrValid = stageValid_r[1];
	assign progAddr      = psAddr_r;
	assign pipeStall     = frontHold;
	assign stageValid    = stageValid_r;
	assign loadWriteback = stageValid_r[`IGD_NSTAGE-1] && !memStall;
endmodule : igd_dispatch

// ==== igd_defines.svh ====
// Constants for the issue group dispatch and no-operation stall block.
`ifndef IGD_DEFINES_SVH
`define IGD_DEFINES_SVH

`define IGD_SLOTS        8
`define IGD_INSTR_W      32
`define IGD_PBIT_POS     0
`define IGD_NOP_CNT_W    4
`define IGD_BRANCH_SLOTS 5
`define IGD_BANKS        8
`define IGD_BANK_W       3
`define IGD_ADDR_W       32
`define IGD_BANK_LSB     1
`define IGD_NSTAGE       10
`define IGD_ST_PR        3
`define IGD_ST_DP        4
`define IGD_ST_E3        8

`endif

// ==== igd_pkg.sv ====
// Types shared by the issue group dispatch block.
`include "igd_defines.svh"
package igd_pkg;
	typedef logic [`IGD_INSTR_W-1:0]                instr_t;
	typedef logic [`IGD_SLOTS-1:0][`IGD_INSTR_W-1:0] fetch_group_t;
	typedef logic [`IGD_SLOTS-1:0]                   slot_mask_t;
	typedef logic [`IGD_NOP_CNT_W-1:0]               nop_cnt_t;
	typedef enum logic [2:0] {
		IGD_RUN    = 3'h1,
		IGD_SPLIT  = 3'h2,
		IGD_NOPRUN = 3'h4
	} igd_state_t;
endpackage : igd_pkg

// ==== igd_stall_if.sv ====
// Stall causes gathered toward the pipeline controller.
`timescale 1ns/1ps
interface igd_stall_if;
	logic bankHit;
	logic memWait;
	modport src (output bankHit, output memWait);
	modport dst (input bankHit, input memWait);
endinterface : igd_stall_if

// ==== igd_mem_stall.sv ====
// Memory readiness and bank conflict detection.
`timescale 1ns/1ps
`include "igd_defines.svh"
module igd_mem_stall (
	// Clock and reset
	input  wire logic                   clk,
	input  wire logic                   rstn,
	// Program fetch state
	input  wire logic                   progWaitValid,
	input  wire logic                   progReady,
	// Data accesses in execute stage three
	input  wire logic                   dataValid0,
	input  wire logic [`IGD_ADDR_W-1:0] dataAddr0,
	input  wire logic                   dataValid1,
	input  wire logic [`IGD_ADDR_W-1:0] dataAddr1,
	input  wire logic                   dataReady,
	// Stall outputs
	igd_stall_if.src                    stall
);
	logic bankHitDone_r;
	wire  [`IGD_BANK_W-1:0] bank0 = dataAddr0[`IGD_BANK_LSB +: `IGD_BANK_W];
	wire  [`IGD_BANK_W-1:0] bank1 = dataAddr1[`IGD_BANK_LSB +: `IGD_BANK_W];
	wire  sameBank = dataValid0 && dataValid1 && (bank0 == bank1);

	// One extra cycle serves the second access of a conflicting pair.
	always_ff @(posedge clk) begin
		if (!rstn) begin
			bankHitDone_r <= 1'b0;
		end else begin
			bankHitDone_r <= sameBank && !bankHitDone_r && !stall.memWait;
		end
	end

	assign stall.bankHit = sameBank && !bankHitDone_r;
	assign stall.memWait = (progWaitValid && !progReady) ||
	                       ((dataValid0 || dataValid1) && !dataReady);
endmodule : igd_mem_stall

// ==== igd_nop_timer.sv ====
// Multicycle no-operation idle counter with branch override.
`timescale 1ns/1ps
`include "igd_defines.svh"
module igd_nop_timer (
	// Clock and reset
	input  wire logic                     clk,
	input  wire logic                     rstn,
	// Control
	input  wire logic                     advance,
	input  wire logic                     load,
	input  wire logic [`IGD_NOP_CNT_W-1:0] count,
	input  wire logic                     branchDone,
	// Status
	output logic                          busy
);
	logic [`IGD_NOP_CNT_W-1:0] remain_r;
	logic [`IGD_NOP_CNT_W-1:0] remain_nxt;

	always_comb begin
		remain_nxt = remain_r;
		if (branchDone) begin
			remain_nxt = '0;
		end else if (load && advance) begin
			remain_nxt = (count > 4'h2) ? count - 4'h2 : 4'h0;
		end else if (advance && remain_r != 4'h0) begin
			remain_nxt = remain_r - 4'h1;
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			remain_r <= '0;
		end else begin
			remain_r <= remain_nxt;
		end
	end

	assign busy = (remain_r != 4'h0);
endmodule : igd_nop_timer

// ==== igd_dispatch_assertions.sv ====
// Port checks for the issue group dispatch block.
`timescale 1ns/1ps
module igd_dispatch_assertions (
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Memory side
	input wire logic progAddrValid,
	input wire logic progReady,
	input wire logic dataValid0,
	input wire logic [31:0] dataAddr0,
	input wire logic dataValid1,
	input wire logic [31:0] dataAddr1,
	input wire logic dataReady,
	// Pipeline side
	input wire logic nopIssue,
	input wire logic [3:0] nopCount,
	input wire logic issueValid,
	input wire igd_pkg::slot_mask_t issueMask,
	input wire logic pipeStall,
	input wire logic [9:0] stageValid
);
	import igd_pkg::*;
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	wire bankSame = dataAddr0[3:1] == dataAddr1[3:1];
	wire dataGo = stageValid[8] && (dataValid0 || dataValid1);
	wire bankHitNow = stageValid[8] && dataValid0 && dataValid1 && bankSame;
	a_prog_wait_stall: assert property (stageValid[2] && !progReady |-> pipeStall)
		else $error("fetch wait not stalled");
	a_data_wait_stall: assert property (dataGo && !dataReady |-> pipeStall)
		else $error("data wait not stalled");
	a_bank_hit_stall: assert property (bankHitNow && !$past(bankHitNow) |-> pipeStall)
		else $error("bank hit not stalled");
	a_front_hold: assert property (pipeStall |=> stageValid[3:0] == $past(stageValid[3:0]))
		else $error("front end moved in stall");
	a_send_valid: assert property (progAddrValid == stageValid[1])
		else $error("address send flag wrong");
	a_nop_two: assert property (issueValid && nopIssue && nopCount == 4'h2 |=> !issueValid)
		else $error("two cycle idle missing");
	a_mask_nonempty: assert property (issueValid |-> issueMask != 8'h00)
		else $error("empty issue group");
	a_issue_from_dp: assert property (issueValid |-> $past(stageValid[4]))
		else $error("issue without dispatch");
endmodule : igd_dispatch_assertions
bind igd_dispatch igd_dispatch_assertions chk (.clk, .rstn, .progAddrValid, .progReady, .dataValid0, .dataAddr0,
	.dataValid1, .dataAddr1, .dataReady, .nopIssue, .nopCount, .issueValid, .issueMask, .pipeStall, .stageValid);

// ==== igd_mem_model.sv ====
// Program memory model giving a fixed slot pattern.
`timescale 1ns/1ps
module igd_mem_model (
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Bench control
	input wire logic slow,
	input wire igd_pkg::slot_mask_t markers,
	// Memory port
	output logic progReady,
	output igd_pkg::fetch_group_t progGroup
);
	import igd_pkg::*;
	logic [1:0] waitCnt_r;
	always_ff @(posedge clk) begin
		waitCnt_r <= !rstn ? 2'h0 : waitCnt_r + 2'h1;
	end
	// Slow mode misses one access wait cycle in four.
	assign progReady = !(slow && waitCnt_r == 2'h3);
	always_comb begin
		for (int s = 0; s < 8; s++) begin
			progGroup[s] = {28'h0, 3'(s), markers[s]};
			if (!progReady) progGroup[s] = ~progGroup[s];
		end
	end
endmodule : igd_mem_model

// ==== igd_dispatch_test.sv ====
// Self-checking bench for the issue group dispatch block.
`timescale 1ns/1ps
`define CHK(a, b) begin testsRun++; if ((a) !== (b)) begin nErrors++; $display("MISMATCH %0t value", $time); end end
module igd_dispatch_test;
	import igd_pkg::*;
	logic clk = 1'b0, rstn = 1'b0, slow = 1'b0, dataOn = 1'b0, sawTgt = 1'b0;
	logic dataValid0 = 1'b0, dataValid1 = 1'b0, dataReady = 1'b1, branchIssue = 1'b0, nopIssue = 1'b0;
	logic [31:0] dataAddr0 = 32'h0, dataAddr1 = 32'h0, tgt = 32'h0, progAddr;
	logic [3:0] nopCount = 4'h0;
	logic [3:0] nops[3] = '{4'h1, 4'h2, 4'h5};
	logic progReady, progAddrValid, issueValid, pipeStall, loadWriteback;
	logic [9:0] stageValid;
	slot_mask_t markers = 8'h00, issueMask;
	fetch_group_t progGroup, issueGroup;
	slot_mask_t expQ[$];
	integer seed = 34789, nErrors = 0, testsRun = 0, cycles = 0, cnt;
	always #2 clk = ~clk;
	igd_dispatch dut (.clk, .rstn, .progAddrValid, .progAddr, .progReady, .progGroup, .dataValid0, .dataAddr0,
		.dataValid1, .dataAddr1, .dataReady, .branchIssue, .branchTarget(tgt), .nopIssue, .nopCount,
		.issueValid, .issueGroup, .issueMask, .pipeStall, .stageValid, .loadWriteback);
	igd_mem_model mem (.clk, .rstn, .slow, .markers, .progReady, .progGroup);
	task automatic conclude();
		if (nErrors == 0 && testsRun > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : conclude
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			nErrors++;
			conclude();
		end
	end
	// Compares each issue group with the oldest expected mask.
	always @(posedge clk) begin
		if (issueValid === 1'b1 && expQ.size() > 0) begin
			`CHK(issueMask, expQ.pop_front())
			for (int s = 0; s < 8; s++) if (issueMask[s]) `CHK(issueGroup[s][31:1], {28'h0, 3'(s)})
		end
		if (progAddrValid && progAddr === tgt) sawTgt <= 1'b1;
	end
	// Random data accesses with collisions and late answers.
	always @(posedge clk) begin
		dataValid0 <= dataOn & 1'($random(seed));
		dataValid1 <= dataOn & 1'($random(seed));
		dataAddr0 <= $random(seed) & 32'hF;
		dataAddr1 <= $random(seed) & 32'hF;
		dataReady <= !dataOn || 1'($random(seed));
	end
	task automatic restart(input slot_mask_t m, input logic s);
		@(posedge clk);
		rstn <= 1'b0;
		markers <= m & 8'h7F;
		slow <= s;
		expQ.delete();
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
	endtask : restart
	// Queues six fetch groups of masks and times their issue; with slow memory it only checks that all were issued.
	task automatic run_groups(input slot_mask_t m, input logic s);
		slot_mask_t g;
		int n;
		restart(m, s);
		for (int f = 0; f < 6; f++) begin
			g = 8'h00;
			for (int k = 0; k < 8; k++) begin
				g[k] = 1'b1;
				if (k == 7 || !m[k]) begin
					expQ.push_back(g);
					g = 8'h00;
				end
			end
		end
		n = expQ.size();
		cnt = 0;
		while (expQ.size() == n && cnt < 100) begin
			@(negedge clk);
			cnt++;
		end
		cnt = 0;
		while (expQ.size() > 0 && cnt < 300) begin
			@(negedge clk);
			cnt++;
		end
		if (!s) `CHK(cnt, n - 1)
		else `CHK(expQ.size(), 0)
	endtask : run_groups
	// Tags the next issue group, then counts cycles to the following one.
	task automatic mark_next(input logic b, input logic [3:0] n, input int d);
		repeat (d) @(posedge clk);
		branchIssue <= b;
		nopIssue <= n != 4'h0;
		nopCount <= n;
		cnt = 0;
		do begin
			@(posedge clk);
			cnt++;
		end while (issueValid !== 1'b1 && cnt < 50);
		branchIssue <= 1'b0;
		nopIssue <= 1'b0;
		cnt = 0;
		do begin
			@(posedge clk);
			cnt++;
		end while (issueValid !== 1'b1 && cnt < 50);
	endtask : mark_next
	initial begin
		run_groups(8'h00, 1'b0);
		run_groups(8'h7F, 1'b0);
		repeat (4) run_groups(8'($random(seed)), 1'b0);
		dataOn = 1'b1;
		repeat (2) run_groups(8'($random(seed)), 1'b1);
		dataOn = 1'b0;
		restart(8'h7F, 1'b0);
		repeat (12) @(posedge clk);
		foreach (nops[i]) begin
			mark_next(1'b0, nops[i], 1);
			`CHK(cnt, nops[i])
		end
		tgt <= $random(seed) & 32'hFFFFFFE0;
		sawTgt = 1'b0;
		mark_next(1'b1, 4'h0, 1);
		mark_next(1'b0, 4'h5, 3);
		`CHK(cnt, 1)
		`CHK(sawTgt, 1'b1)
		conclude();
	end
endmodule : igd_dispatch_test
